/* logic/qdsl_pkg.sv */
// Purpose: Shared constants and types for the quad converter serial loader.
// Assumes: AXI4-Lite register port with 32-bit data and 8-bit addresses.
package qdsl_pkg;

  // ****************************************************************
  // Word layout and converter codes
  // ****************************************************************
  localparam int DATA_W  = 12;
  localparam int WORD_W  = 16;
  localparam int CHAN_N  = 4;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int AXI_AW  = 8;
  localparam int AXI_DW  = 32;
  localparam int CNT_W   = 8;

  localparam logic [DATA_W-1:0] CODE_MID  = 12'h800;
  localparam logic [DATA_W-1:0] CODE_ZERO = 12'h000;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [AXI_AW-1:0] OFF_CTRL  = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_STAT  = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_WORD  = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_CHAN0 = 8'h10;

  localparam int CTRL_SOFTCLR = 0;
  localparam int STAT_CLRPIN  = 0;
  localparam int STAT_LDPIN   = 1;
  localparam int STAT_LVLPIN  = 2;
  localparam int STAT_CLRACT  = 3;
  localparam int STAT_CNT_LO  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Idle levels of the synchronised pins: clear high, load high, level low.
  localparam logic [2:0] PIN_IDLE = 3'b110;

  // ****************************************************************
  // Bus state machines
  // ****************************************************************
  typedef enum logic [0:0]
  {
    QDSL_WR_COLLECT = 1'b0,
    QDSL_WR_RESP    = 1'b1
  } qdsl_wr_e;

  typedef enum logic [0:0]
  {
    QDSL_RD_IDLE = 1'b0,
    QDSL_RD_DATA = 1'b1
  } qdsl_rd_e;

endpackage : qdsl_pkg

/* logic/qdsl_sync.sv */
// Purpose: Two-stage synchroniser for slow level inputs.
// Assumes: Inputs are levels that stay put for several clock periods.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/10ps
module qdsl_sync
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // Both stages settle to the idle level during reset.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;

endmodule : qdsl_sync

/* logic/qdsl_core.sv */
// Purpose: Serial shift front end and four channel code registers.
// Assumes: The host keeps the shift word still while the load strobe is low.
// Notes:   Load, clear and level pins are sampled on mclk after two flops.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module qdsl_core
  import qdsl_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic                          linkClk,
  input  wire logic                          deviceSelectN,
  input  wire logic                          serial_data_in,
  input  wire logic                          load_strobe_n,
  input  wire logic                          clear_n,
  input  wire logic                          clear_level_select,
  input  wire logic [qdsl_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [qdsl_pkg::AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [qdsl_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [qdsl_pkg::AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [qdsl_pkg::DATA_W-1:0]        dacCodeA,
  output logic [qdsl_pkg::DATA_W-1:0]        dacCodeB,
  output logic [qdsl_pkg::DATA_W-1:0]        dacCodeC,
  output logic [qdsl_pkg::DATA_W-1:0]        dacCodeD
);

  import qdsl_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                linkShiftClk;
  logic [WORD_W-1:0]   shiftWord_r;
  logic [2:0]          pinSync;
  logic                loadSyncN;
  logic                clearSyncN;
  logic                levelSyncHi;
  logic                loadPrev_r;
  logic                loadFall;
  logic                clearing;
  logic [DATA_W-1:0]   clearVal;
  logic [1:0]          selChan;
  logic [DATA_W-1:0]   dacReg_r [CHAN_N];
  logic [WORD_W-1:0]   lastWord_r;
  logic [CNT_W-1:0]    loadCount_r;
  logic                softClear_r;
  qdsl_wr_e            wrState_r;
  qdsl_rd_e            rdState_r;
  logic                awReady_r;
  logic                wReady_r;
  logic                awHeld_r;
  logic                wHeld_r;
  logic [AXI_AW-1:0]   awAddr_r;
  logic [AXI_DW-1:0]   wData_r;
  logic [3:0]          wStrb_r;
  logic                bValid_r;
  logic [1:0]          bResp_r;
  logic                arReady_r;
  logic                rValid_r;
  logic [1:0]          rResp_r;
  logic [AXI_DW-1:0]   rData_r;
  logic                wrFire;
  logic                wrHit;
  logic [AXI_DW-1:0]   rdMuxData;
  logic [1:0]          rdMuxResp;

  // ****************************************************************
  // Link domain: serial shift word
  // ****************************************************************
  // The shift clock is the link clock ORed with select, so a select
  // rise while the clock is low also shifts one bit.
  assign linkShiftClk = linkClk | deviceSelectN;

  // Address high bit enters first and ends up in the top bit. With
  // select high the gated clock sits high, so no edge reaches the word.
  // The clear pin has no path into this register at all.
  always_ff @(posedge linkShiftClk)
  begin
    shiftWord_r <= {shiftWord_r[WORD_W-2:0], serial_data_in};
  end

  // ****************************************************************
  // Pin synchronisers into the mclk domain
  // ****************************************************************
  qdsl_sync
  #(
    .WIDTH     (3),
    .RESET_VAL (PIN_IDLE)
  )
  u_pinSync
  (
    .mclk    (mclk),
    .nrst    (nrst),
    .asyncIn ({load_strobe_n, clear_n, clear_level_select}),
    .syncOut (pinSync)
  );

  assign loadSyncN   = pinSync[2];
  assign clearSyncN  = pinSync[1];
  assign levelSyncHi = pinSync[0];

  // ****************************************************************
  // Load and clear decode
  // ****************************************************************
  // The shift word is read here only while load is low, when the host
  // holds it still, so the multi-bit crossing sees settled data.
  assign loadFall = loadPrev_r & ~loadSyncN;
  assign clearing = ~clearSyncN | softClear_r;
  assign clearVal = levelSyncHi ? CODE_MID : CODE_ZERO;
  assign selChan  = shiftWord_r[ADDR_HI:ADDR_LO];

  // Previous load level, used to spot the falling edge.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      loadPrev_r <= 1'b1;
    end
    else
    begin
      loadPrev_r <= loadSyncN;
    end
  end

  // ****************************************************************
  // Channel code registers
  // ****************************************************************
  // Clear wins over load; load low writes the addressed channel each
  // cycle, so the first cycle is the edge copy and later ones follow.
  // Once clear releases the codes simply stay until the next load.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < CHAN_N; i++)
      begin
        dacReg_r[i] <= CODE_ZERO;
      end
    end
    else if (clearing)
    begin
      for (int i = 0; i < CHAN_N; i++)
      begin
        dacReg_r[i] <= clearVal;
      end
    end
    else if (!loadSyncN)
    begin
      dacReg_r[selChan] <= shiftWord_r[DATA_W-1:0];
    end
  end

  assign dacCodeA = dacReg_r[0];
  assign dacCodeB = dacReg_r[1];
  assign dacCodeC = dacReg_r[2];
  assign dacCodeD = dacReg_r[3];

  // Last word taken from the shift register and a count of load edges.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      lastWord_r  <= '0;
      loadCount_r <= '0;
    end
    else
    begin
      if (!loadSyncN)
      begin
        lastWord_r <= shiftWord_r;
      end
      if (loadFall)
      begin
        loadCount_r <= loadCount_r + CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are taken in either order; the write and the
  // response are both registered on the edge that ends the cycle both are held.
  assign wrFire = (wrState_r == QDSL_WR_COLLECT) && awHeld_r && wHeld_r;
  assign wrHit  = (awAddr_r[AXI_AW-1:2] == OFF_CTRL[AXI_AW-1:2])
               || (awAddr_r[AXI_AW-1:2] == OFF_STAT[AXI_AW-1:2])
               || (awAddr_r[AXI_AW-1:2] == OFF_WORD[AXI_AW-1:2])
               || (awAddr_r[AXI_AW-1:4] == OFF_CHAN0[AXI_AW-1:4]);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wrState_r <= QDSL_WR_COLLECT;
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= '0;
      wStrb_r   <= '0;
      bValid_r  <= 1'b0;
      bResp_r   <= RESP_OKAY;
    end
    else
    begin
      case (wrState_r)
        QDSL_WR_COLLECT:
        begin
          if (s_axi_awvalid && awReady_r)
          begin
            awAddr_r  <= s_axi_awaddr;
            awHeld_r  <= 1'b1;
            awReady_r <= 1'b0;
          end
          if (s_axi_wvalid && wReady_r)
          begin
            wData_r  <= s_axi_wdata;
            wStrb_r  <= s_axi_wstrb;
            wHeld_r  <= 1'b1;
            wReady_r <= 1'b0;
          end
          if (wrFire)
          begin
            awHeld_r  <= 1'b0;
            wHeld_r   <= 1'b0;
            bValid_r  <= 1'b1;
            bResp_r   <= wrHit ? RESP_OKAY : RESP_SLVERR;
            wrState_r <= QDSL_WR_RESP;
          end
        end
        QDSL_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            bValid_r  <= 1'b0;
            awReady_r <= 1'b1;
            wReady_r  <= 1'b1;
            wrState_r <= QDSL_WR_COLLECT;
          end
        end
        default:
        begin
          wrState_r <= QDSL_WR_COLLECT;
        end
      endcase
    end
  end

  // Software clear bit; acts like the clear pin while it is set.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      softClear_r <= 1'b0;
    end
    else if (wrFire && wStrb_r[0]
             && (awAddr_r[AXI_AW-1:2] == OFF_CTRL[AXI_AW-1:2]))
    begin
      softClear_r <= wData_r[CTRL_SOFTCLR];
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Address decode of the read port; unmapped words answer SLVERR.
  always_comb
  begin
    rdMuxData = '0;
    rdMuxResp = RESP_OKAY;
    if (s_axi_araddr[AXI_AW-1:2] == OFF_CTRL[AXI_AW-1:2])
    begin
      rdMuxData[CTRL_SOFTCLR] = softClear_r;
    end
    else if (s_axi_araddr[AXI_AW-1:2] == OFF_STAT[AXI_AW-1:2])
    begin
      rdMuxData[STAT_CLRPIN] = clearSyncN;
      rdMuxData[STAT_LDPIN]  = loadSyncN;
      rdMuxData[STAT_LVLPIN] = levelSyncHi;
      rdMuxData[STAT_CLRACT] = clearing;
      rdMuxData[STAT_CNT_LO +: CNT_W] = loadCount_r;
    end
    else if (s_axi_araddr[AXI_AW-1:2] == OFF_WORD[AXI_AW-1:2])
    begin
      rdMuxData[WORD_W-1:0] = lastWord_r;
    end
    else if (s_axi_araddr[AXI_AW-1:4] == OFF_CHAN0[AXI_AW-1:4])
    begin
      rdMuxData[DATA_W-1:0] = dacReg_r[s_axi_araddr[3:2]];
    end
    else
    begin
      rdMuxResp = RESP_SLVERR;
    end
  end

  // Read data is registered on the same edge that the address is taken.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rdState_r <= QDSL_RD_IDLE;
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rResp_r   <= RESP_OKAY;
      rData_r   <= '0;
    end
    else
    begin
      case (rdState_r)
        QDSL_RD_IDLE:
        begin
          if (s_axi_arvalid && arReady_r)
          begin
            rData_r   <= rdMuxData;
            rResp_r   <= rdMuxResp;
            rValid_r  <= 1'b1;
            arReady_r <= 1'b0;
            rdState_r <= QDSL_RD_DATA;
          end
        end
        QDSL_RD_DATA:
        begin
          if (s_axi_rready)
          begin
            rValid_r  <= 1'b0;
            arReady_r <= 1'b1;
            rdState_r <= QDSL_RD_IDLE;
          end
        end
        default:
        begin
          rdState_r <= QDSL_RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rresp   = rResp_r;
  assign s_axi_rdata   = rData_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // The shift word has no reset, so this check never disables.
  property p_link_shift;
    @(posedge linkShiftClk) disable iff (1'b0)
    1'b1 |=> (shiftWord_r[0] === $past(serial_data_in))
          && (shiftWord_r[WORD_W-1:1] === $past(shiftWord_r[WORD_W-2:0]));
  endproperty
  a_link_shift: assert property (p_link_shift)
    else $error("Shift word did not take the serial bit.");

  sequence s_clear_mid;
    !clearSyncN && levelSyncHi;
  endsequence

  sequence s_clear_zero;
    !clearSyncN && !levelSyncHi;
  endsequence

  property p_clear_mid;
    @(posedge mclk) disable iff (!nrst)
    s_clear_mid |=> (dacReg_r[0] == CODE_MID) && (dacReg_r[1] == CODE_MID)
                 && (dacReg_r[2] == CODE_MID) && (dacReg_r[3] == CODE_MID);
  endproperty
  a_clear_mid: assert property (p_clear_mid)
    else $error("Clear with level high did not give midscale.");

  property p_clear_zero;
    @(posedge mclk) disable iff (!nrst)
    s_clear_zero |=> (dacReg_r[0] == CODE_ZERO) && (dacReg_r[1] == CODE_ZERO)
                  && (dacReg_r[2] == CODE_ZERO) && (dacReg_r[3] == CODE_ZERO);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Clear with level low did not give zero.");

  property p_clear_over_load;
    @(posedge mclk) disable iff (!nrst)
    (!clearSyncN && !loadSyncN) |=> dacReg_r[0] == $past(clearVal);
  endproperty
  a_clear_over_load: assert property (p_clear_over_load)
    else $error("Load overrode an active clear.");

  property p_hold_after_clear;
    @(posedge mclk) disable iff (!nrst)
    ($fell(clearing) && loadSyncN)
      |=> (dacReg_r[0] == $past(clearVal, 2))
       && (dacReg_r[3] == $past(clearVal, 2));
  endproperty
  a_hold_after_clear: assert property (p_hold_after_clear)
    else $error("Channels lost the clear value before a load.");

  sequence s_load_fall;
    loadFall && !clearing;
  endsequence

  property p_load_select;
    @(posedge mclk) disable iff (!nrst)
    s_load_fall |=> dacReg_r[$past(selChan)] == $past(shiftWord_r[DATA_W-1:0]);
  endproperty
  a_load_select: assert property (p_load_select)
    else $error("Load edge did not copy data to the addressed channel.");

  property p_load_others;
    @(posedge mclk) disable iff (!nrst)
    (s_load_fall ##0 (selChan != 2'b00)) |=> $stable(dacReg_r[0]);
  endproperty
  a_load_others: assert property (p_load_others)
    else $error("Load changed a channel that was not addressed.");

  property p_transparent;
    @(posedge mclk) disable iff (!nrst)
    (!loadSyncN && !clearing)[*3]
      |=> dacReg_r[$past(selChan)] == $past(shiftWord_r[DATA_W-1:0]);
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("Channel did not follow the word while load was low.");

  // A pending response either holds still or retires and reopens the
  // address and data channels in the cycle after bready is seen.
  property p_bresp_hold;
    @(posedge mclk) disable iff (!nrst)
    bValid_r |=> $past(s_axi_bready) ? (!bValid_r && awReady_r && wReady_r)
                                     : (bValid_r && $stable(bResp_r));
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("Write response dropped or not retired on bready.");

endmodule : qdsl_core

/* verification/qdsl_host_model.sv */
// Purpose: Host model that drives the serial link of the loader.
// Assumes: Link clock of 48 ns period, halted high between words.
// Notes:   After a word the data line shows the inverse of its last value.
`timescale 1ns/10ps
module qdsl_host_model
(
  output logic linkClk,
  output logic deviceSelectN,
  output logic serial_data_in
);
  // Idle state: clock halted high and select high.
  initial
  begin
    linkClk        = 1'b1;
    deviceSelectN  = 1'b1;
    serial_data_in = 1'b0;
  end

  // Sends one word first bit on top; the last edge may come from select.
  task automatic send_word(input logic [15:0] w, input bit selEdge);
    // Offset keeps link edges away from the system clock edges.
    #7;
    deviceSelectN = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--)
    begin
      linkClk        = 1'b0;
      serial_data_in = w[i];
      #24;
      if (i == 0 && selEdge)
        deviceSelectN = 1'b1;
      else
        linkClk = 1'b1;
      #24;
    end
    linkClk = 1'b1;
    #24;
    deviceSelectN  = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask : send_word

  // Toggles the link clock with select high and noisy data.
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      linkClk        = 1'b0;
      serial_data_in = 1'($urandom_range(1));
      #24;
      linkClk = 1'b1;
      #24;
    end
  endtask : idle_clocks
endmodule : qdsl_host_model

/* verification/quad_dac_serial_load_clear_test.sv */
// Purpose: Self-checking bench for the quad converter serial loader.
// Assumes: Load and clear act three mclk edges after their pins change.
// Notes:   A behavioural model of the four channels gives the expected channel codes.
`timescale 1ns/10ps
module quad_dac_serial_load_clear_test;
  import qdsl_pkg::*;
  logic mclk, nrst, linkClk, deviceSelectN, serial_data_in;
  logic load_strobe_n, clear_n, clear_level_select;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [11:0] dacCodeA, dacCodeB, dacCodeC, dacCodeD;
  logic [31:0] rd;
  logic [15:0] w;
  int err_total, samples_checked, expCode[4], loadCnt, sel;

  qdsl_host_model host (.linkClk(linkClk), .deviceSelectN(deviceSelectN),
    .serial_data_in(serial_data_in));
  qdsl_core uut (.*);

  // ****************************************************************
  // Clock, checks and bus tasks
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Compares all four channel outputs with the model.
  task automatic chk_codes();
    chk("codeA", expCode[0], {20'h0, dacCodeA});
    chk("codeB", expCode[1], {20'h0, dacCodeB});
    chk("codeC", expCode[2], {20'h0, dacCodeC});
    chk("codeD", expCode[3], {20'h0, dacCodeD});
  endtask : chk_codes

  // One write; both channels offered together, released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // One read; rready held until the data is sampled.
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Strobes load and updates the model from the last shifted word.
  task automatic pulse_load();
    @(posedge mclk);
    load_strobe_n <= 1'b0;
    repeat (5) @(posedge mclk);
    load_strobe_n <= 1'b1;
    repeat (5) @(posedge mclk);
    expCode[w[15:14]] = int'(w[11:0]);
    loadCnt++;
  endtask : pulse_load

  // Sends a random word to one channel and loads it.
  task automatic send_load(input int ch, input bit selEdge);
    w = {2'(ch), 14'($urandom)};
    host.send_word(w, selEdge);
    pulse_load();
  endtask : send_load

  // Ends the run with counts and verdict.
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog against a hung handshake.
  initial
  begin
    #200000;
    err_total++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {load_strobe_n, clear_n, clear_level_select} = 3'b110;
    nrst = 1'b0;
    void'($urandom(32'hdba7));
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    chk_codes();
    for (int c = 0; c < 4; c++)
    begin
      axi_rd(8'(OFF_CHAN0 + 4 * c));
      chk("chanReg", 32'h0, rd);
      chk("chanResp", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    for (int c = 0; c < 4; c++)
    begin
      send_load(c, 1'b0);
      chk_codes();
    end
    send_load($urandom_range(3), 1'b1);
    chk_codes();
    sel = $urandom_range(3);
    w = {2'(sel), 14'($urandom)};
    host.send_word(w, 1'b0);
    @(posedge mclk);
    load_strobe_n <= 1'b0;
    repeat (5) @(posedge mclk);
    axi_rd(OFF_WORD);
    chk("wordLoadLow", {16'h0, w}, rd);
    expCode[sel] = int'(w[11:0]);
    chk_codes();
    load_strobe_n <= 1'b1;
    loadCnt++;
    repeat (5) @(posedge mclk);
    host.idle_clocks(8);
    pulse_load();
    chk_codes();
    for (int lv = 0; lv < 2; lv++)
    begin
      clear_level_select <= lv[0];
      clear_n <= 1'b0;
      load_strobe_n <= 1'b0;
      repeat (6) @(posedge mclk);
      load_strobe_n <= 1'b1;
      loadCnt++;
      repeat (6) @(posedge mclk);
      for (int c = 0; c < 4; c++) expCode[c] = lv ? 'h800 : 'h000;
      chk_codes();
      clear_n <= 1'b1;
      repeat (6) @(posedge mclk);
      chk_codes();
      pulse_load();
      chk_codes();
    end
    axi_rd(OFF_STAT);
    chk("loadCount", loadCnt & 'hff, (rd >> STAT_CNT_LO) & 'hff);
    chk("pinBits", 32'h7, rd & 'h7);
    axi_rd(8'h40);
    chk("unmappedRd", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("unmappedData", 32'h0, rd);
    axi_wr(8'h40, 32'h1);
    chk("unmappedWr", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_wr(OFF_STAT, 32'hffff_ffff);
    chk("roWrite", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_wr(OFF_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 4; c++) expCode[c] = 'h800;
    chk_codes();
    axi_rd(OFF_CTRL);
    chk("ctrlBack", 32'h1, rd & 'h1);
    axi_wr(OFF_CTRL, 32'h0);
    print_verdict();
  end
endmodule : quad_dac_serial_load_clear_test
